// file: design/fdc_status.sv
// Status register and track write sequencer of a floppy controller.
// Assumes synchronous host strobes and drive inputs; one 25 MHz clock.
`include "fdc_status_params.svh"

// ----------------------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------------------
module fdc_byte_fifo #(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Drain side
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic [WIDTH-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    // Honest full and empty
    assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_reg != '0);
    assign rd_data_out  = mem_reg[rptr_reg];
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;

    // Pointer and count update
    always_comb begin
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
        cnt_next  = cnt_reg;
        if (push && !pop) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
        end
    end

    // Array write, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_reg[wptr_reg] <= wr_data_in;
        end
    end
endmodule // fdc_byte_fifo

// ----------------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------------
module fdc_status
    import fdc_status_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_SYS_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       MASTER_RESET_N_IN,
    // Host register port
    input  wire logic       CS_N_IN,
    input  wire logic       RE_N_IN,
    input  wire logic       WE_N_IN,
    input  wire logic [1:0] ADDR_IN,
    input  wire logic [7:0] DATA_IN,
    output logic [7:0]      DATA_OUT,
    output logic            DATA_OE_OUT,
    output logic            DATA_REQUEST_FLAG_OUT,
    output logic            INTERRUPT_REQUEST_OUT,
    // Drive status lines
    input  wire logic       READY_IN,
    input  wire logic       WRITE_PROTECT_N_IN,
    input  wire logic       TRACK_ZERO_N_IN,
    input  wire logic       INDEX_PULSE_N_IN,
    input  wire logic       HEAD_ENGAGED_IN,
    input  wire logic       WRITE_FAULT_N_IN,
    input  wire logic       DOUBLE_DENSITY_IN,
    // Events from the read and seek logic
    input  wire logic       SEEK_ERROR_IN,
    input  wire logic       RECORD_MISSING_IN,
    input  wire logic       CRC_ERROR_IN,
    input  wire logic       DELETED_MARK_IN,
    input  wire logic       READ_BYTE_VALID_IN,
    input  wire logic [7:0] READ_BYTE_IN,
    input  wire logic       CMD_DONE_IN,
    // Drive write path
    output logic            HEAD_LOAD_OUT,
    output logic            DISK_BYTE_VALID_OUT,
    output logic [7:0]      DISK_BYTE_OUT,
    input  wire logic       DISK_BYTE_READY_IN
);
    // Host strobes
    logic       rd_stb, wr_stb, rd_stat_prev, wr_prev;
    logic       rd_now, wr_now, rd_edge, wr_edge;
    assign rd_now  = !CS_N_IN && !RE_N_IN;
    assign wr_now  = !CS_N_IN && !WE_N_IN;
    assign rd_edge = rd_now && !rd_stat_prev;
    assign wr_edge = wr_now && !wr_prev;
    assign rd_stb  = rd_edge;
    assign wr_stb  = wr_edge;

    // State registers
    seq_state_e  state_reg, state_next;
    cmd_class_e  cls_reg, cls_next;
    err_flags_s  err_reg, err_next;
    logic [3:0]  cmd_reg, cmd_next;
    logic [7:0]  track_reg, track_next, sector_reg, sector_next;
    logic [7:0]  data_reg, data_next, dout_reg, dout_next;
    logic        busy_reg, busy_next, drq_reg, drq_next, irq_reg, irq_next;
    logic        hld_reg, hld_next;
    logic [15:0] crc_reg, crc_next, lost_cnt_reg, lost_cnt_next;
    disk_byte_s  dbyte_reg, dbyte_next;
    logic [7:0]  status;

    // FIFO between host data writes and the drive byte stream
    logic       fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
    logic [7:0] fifo_rd_data;
    logic       data_wr, data_rd, fifo_push, wr_cls, wr_cmd;
    // Only write classes feed the drive; read track also has bit 5 set
    assign wr_cls    = cls_reg == CLS_WR_SECT
                       || (cls_reg == CLS_TRACK && cmd_reg == `CMD_WR_TRACK);
    assign wr_cmd    = DATA_IN[5] && DATA_IN[7:4] != `CMD_RD_TRACK;
    assign data_wr   = wr_stb && ADDR_IN == `SEL_DATA;
    assign data_rd   = rd_stb && ADDR_IN == `SEL_DATA;
    assign fifo_push = data_wr && busy_reg && wr_cls;

    fdc_byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk_in      (CLK_SYS_IN),
        .rst_n_in    (RST_N_IN),
        .wr_valid_in (fifo_push),
        .wr_ready_out(fifo_wr_ready),
        .wr_data_in  (DATA_IN),
        .rd_valid_out(fifo_rd_valid),
        .rd_ready_in (fifo_rd_ready),
        .rd_data_out (fifo_rd_data)
    );
    // Sequencer drains only in run state when the drive slot is free
    assign fifo_rd_ready = state_reg == ST_RUN && !dbyte_reg.valid;

    // CCITT step over one byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Status composition per command type
    always_comb begin
        status = 8'h00;
        status[`ST_NOT_READY] = !READY_IN || !MASTER_RESET_N_IN;
        status[`ST_BUSY]      = busy_reg;
        case (cls_reg)
            CLS_POSITION: begin
                status[`ST_BIT6] = !WRITE_PROTECT_N_IN;
                status[`ST_BIT5] = hld_reg && HEAD_ENGAGED_IN;
                status[`ST_BIT4] = err_reg.seek_err;
                status[`ST_BIT3] = err_reg.crc_err;
                status[`ST_BIT2] = !TRACK_ZERO_N_IN;
                status[`ST_BIT1] = !INDEX_PULSE_N_IN;
            end
            default: begin
                status[`ST_BIT6] = err_reg.protect;
                status[`ST_BIT5] = err_reg.mark_or_fault;
                status[`ST_BIT4] = err_reg.record_missing_flag;
                status[`ST_BIT3] = err_reg.crc_err;
                status[`ST_BIT2] = err_reg.lost_data;
                status[`ST_BIT1] = drq_reg;
                if (cls_reg == CLS_TRACK && cmd_reg == `CMD_RD_TRACK) begin
                    status[`ST_BIT6:`ST_BIT3] = 4'h0;
                end
                if (cls_reg == CLS_TRACK && cmd_reg == `CMD_WR_TRACK) begin
                    status[`ST_BIT4:`ST_BIT3] = 2'h0;
                end
                if (cls_reg == CLS_RD_SECT && cmd_reg == `CMD_RD_ADDR) begin
                    status[`ST_BIT6:`ST_BIT5] = 2'h0;
                end
            end
        endcase
    end

    // Command, flags and sequencer next state
    always_comb begin
        state_next    = state_reg;
        cls_next      = cls_reg;
        err_next      = err_reg;
        cmd_next      = cmd_reg;
        track_next    = track_reg;
        sector_next   = sector_reg;
        data_next     = data_reg;
        busy_next     = busy_reg;
        drq_next      = drq_reg;
        irq_next      = irq_reg;
        hld_next      = hld_reg;
        crc_next      = crc_reg;
        lost_cnt_next = lost_cnt_reg;
        dbyte_next    = dbyte_reg;
        dout_next     = dout_reg;
        if (dbyte_reg.valid && DISK_BYTE_READY_IN) begin
            dbyte_next.valid = 1'b0;
        end
        // Register reads
        if (rd_stb) begin
            case (ADDR_IN)
                `SEL_STATUS_CMD: dout_next = status;
                `SEL_TRACK:      dout_next = track_reg;
                `SEL_SECTOR:     dout_next = sector_reg;
                default:         dout_next = data_reg;
            endcase
        end
        // Data register access clears the request
        if (data_wr || data_rd) begin
            drq_next      = 1'b0;
            lost_cnt_next = 16'h0000;
        end
        if (data_wr) begin
            data_next = DATA_IN;
        end
        if (wr_stb && ADDR_IN == `SEL_TRACK) begin
            track_next = DATA_IN;
        end
        if (wr_stb && ADDR_IN == `SEL_SECTOR) begin
            sector_next = DATA_IN;
        end
        // Drive events set sticky flags
        if (busy_reg) begin
            if (SEEK_ERROR_IN) err_next.seek_err = 1'b1;
            if (RECORD_MISSING_IN) err_next.record_missing_flag = 1'b1;
            if (CRC_ERROR_IN) err_next.crc_err = 1'b1;
            if (cls_reg == CLS_RD_SECT && DELETED_MARK_IN) err_next.mark_or_fault = 1'b1;
            if (wr_cls && !WRITE_FAULT_N_IN) begin
                err_next.mark_or_fault = 1'b1;
            end
            if (cls_reg == CLS_RD_SECT && READ_BYTE_VALID_IN) begin
                data_next = READ_BYTE_IN;
                drq_next  = 1'b1;
            end
            // Lost data after one byte time unserviced
            if (drq_reg && cls_reg != CLS_POSITION) begin
                lost_cnt_next = lost_cnt_reg + 16'h0001;
                if (lost_cnt_reg == 16'(`BYTE_CYCLES)) begin
                    err_next.lost_data = 1'b1;
                    lost_cnt_next = 16'h0000;
                end
            end
            if (wr_cls && fifo_wr_ready && !fifo_push) begin
                drq_next = 1'b1;
            end
            if (CMD_DONE_IN) begin
                busy_next  = 1'b0;
                irq_next   = 1'b1;
                drq_next   = 1'b0;
                state_next = ST_IDLE;
            end
        end
        // Drive write sequencer, gaps of any length pass through
        case (state_reg)
            ST_IDLE: begin
            end
            ST_RUN: begin
                if (fifo_rd_valid && !dbyte_reg.valid) begin
                    if (fifo_rd_data == `BYTE_CRC) begin
                        state_next = ST_CRC_H;
                    end else if (fifo_rd_data == `BYTE_SYNC_MFM && DOUBLE_DENSITY_IN) begin
                        dbyte_next = '{valid: 1'b1, data: `BYTE_SYNC_OUT};
                        crc_next   = crc_byte(`CRC_PRESET, `BYTE_SYNC_OUT);
                    end else begin
                        dbyte_next = '{valid: 1'b1, data: fifo_rd_data};
                        crc_next   = crc_byte(crc_reg, fifo_rd_data);
                    end
                end
            end
            ST_CRC_H: begin
                if (!dbyte_reg.valid) begin
                    dbyte_next = '{valid: 1'b1, data: crc_reg[15:8]};
                    state_next = ST_CRC_L;
                end
            end
            ST_CRC_L: begin
                if (!dbyte_reg.valid) begin
                    dbyte_next = '{valid: 1'b1, data: crc_reg[7:0]};
                    state_next = ST_RUN;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Command register write, last so it takes priority
        if (wr_stb && ADDR_IN == `SEL_STATUS_CMD) begin
            irq_next = 1'b0;
            if (DATA_IN[7:4] == `CMD_FORCE_INT) begin
                busy_next  = 1'b0;
                state_next = ST_IDLE;
                if (!busy_reg) begin
                    cls_next = CLS_POSITION;
                    err_next = '0;
                end
                if (DATA_IN[3]) irq_next = 1'b1;
            end else begin
                cmd_next      = DATA_IN[7:4];
                err_next      = '0;
                drq_next      = 1'b0;
                lost_cnt_next = 16'h0000;
                crc_next      = `CRC_PRESET;
                hld_next      = 1'b1;
                if (!DATA_IN[7]) begin
                    cls_next  = CLS_POSITION;
                    busy_next = 1'b1;
                end else begin
                    cls_next = DATA_IN[6] ? ((DATA_IN[5:4] == 2'h0) ? CLS_RD_SECT : CLS_TRACK)
                                          : (DATA_IN[5] ? CLS_WR_SECT : CLS_RD_SECT);
                    if (!READY_IN) begin
                        irq_next = 1'b1;
                    end else begin
                        busy_next = 1'b1;
                        if (wr_cmd && !WRITE_PROTECT_N_IN) begin
                            err_next.protect = 1'b1;
                            busy_next = 1'b0;
                            irq_next  = 1'b1;
                        end else if (wr_cmd) begin
                            state_next = ST_RUN;
                        end
                    end
                end
            end
        end
    end

    // Registers
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_reg    <= ST_IDLE;
            cls_reg      <= CLS_POSITION;
            err_reg      <= '0;
            cmd_reg      <= 4'(`CMD_RESET_VAL >> 4);
            track_reg    <= `REG_RESET_VAL;
            sector_reg   <= `REG_RESET_VAL;
            data_reg     <= `REG_RESET_VAL;
            dout_reg     <= `REG_RESET_VAL;
            busy_reg     <= 1'b0;
            drq_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            hld_reg      <= 1'b0;
            crc_reg      <= `CRC_PRESET;
            lost_cnt_reg <= 16'h0000;
            dbyte_reg    <= '0;
            rd_stat_prev <= 1'b0;
            wr_prev      <= 1'b0;
        end else if (!MASTER_RESET_N_IN) begin
            state_reg    <= ST_IDLE;
            busy_reg     <= 1'b0;
            drq_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            err_reg      <= '0;
            dbyte_reg    <= '0;
            dout_reg     <= dout_next;
            rd_stat_prev <= rd_now;
            wr_prev      <= wr_now;
        end else begin
            state_reg    <= state_next;
            cls_reg      <= cls_next;
            err_reg      <= err_next;
            cmd_reg      <= cmd_next;
            track_reg    <= track_next;
            sector_reg   <= sector_next;
            data_reg     <= data_next;
            dout_reg     <= dout_next;
            busy_reg     <= busy_next;
            drq_reg      <= drq_next;
            irq_reg      <= irq_next;
            hld_reg      <= hld_next;
            crc_reg      <= crc_next;
            lost_cnt_reg <= lost_cnt_next;
            dbyte_reg    <= dbyte_next;
            rd_stat_prev <= rd_now;
            wr_prev      <= wr_now;
        end
    end

    // Outputs
    assign DATA_OUT              = dout_reg;
    assign DATA_OE_OUT           = rd_now;
    assign DATA_REQUEST_FLAG_OUT = drq_reg;
    assign INTERRUPT_REQUEST_OUT = irq_reg;
    assign HEAD_LOAD_OUT         = hld_reg;
    assign DISK_BYTE_VALID_OUT   = dbyte_reg.valid;
    assign DISK_BYTE_OUT         = dbyte_reg.data;
endmodule // fdc_status

// file: include/fdc_status_params.svh
// Constants for the floppy status and track format block.
// Assumes inclusion by design and bench files by bare name.
`ifndef FDC_STATUS_PARAMS_SVH
`define FDC_STATUS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------------------
`define SEL_STATUS_CMD  2'h0
`define SEL_TRACK       2'h1
`define SEL_SECTOR      2'h2
`define SEL_DATA        2'h3

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define ST_NOT_READY    7
`define ST_BIT6         6
`define ST_BIT5         5
`define ST_BIT4         4
`define ST_BIT3         3
`define ST_BIT2         2
`define ST_BIT1         1
`define ST_BUSY         0

// ----------------------------------------------------------------------------
// Command codes (upper nibble) and reset values
// ----------------------------------------------------------------------------
`define CMD_FORCE_INT   4'hd
`define CMD_RD_ADDR     4'hc
`define CMD_RD_TRACK    4'he
`define CMD_WR_TRACK    4'hf
`define CMD_RESET_VAL   8'h03
`define REG_RESET_VAL   8'h00

// ----------------------------------------------------------------------------
// Track write control bytes and timing
// ----------------------------------------------------------------------------
`define BYTE_CRC        8'hf7
`define BYTE_SYNC_MFM   8'hf5
`define BYTE_SYNC_OUT   8'ha1
`define BYTE_ZERO       8'h00
`define CRC_PRESET      16'hffff
`define CRC_POLY        16'h1021
`define CLK_MHZ         25
`define BYTE_TIME_US    32
`define BYTE_CYCLES     (`BYTE_TIME_US * `CLK_MHZ)
`define FIFO_DEPTH      16
`define FIFO_WIDTH      8
`endif

// file: include/fdc_status_pkg.sv
// Types for the floppy status and track format block.
// Assumes nothing beyond the params header.
package fdc_status_pkg;
    // Command class
    typedef enum logic [3:0] {
        CLS_POSITION = 4'h1,
        CLS_RD_SECT  = 4'h2,
        CLS_WR_SECT  = 4'h4,
        CLS_TRACK    = 4'h8
    } cmd_class_e;

    // Sequencer state
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RUN   = 4'h2,
        ST_CRC_H = 4'h4,
        ST_CRC_L = 4'h8
    } seq_state_e;

    // Sticky error flags
    typedef struct packed {
        logic seek_err;
        logic record_missing_flag;
        logic crc_err;
        logic lost_data;
        logic mark_or_fault;
        logic protect;
    } err_flags_s;

    // Byte headed to the drive serialiser
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } disk_byte_s;
endpackage

// file: sim/fdc_drive_model.sv
// Drive side byte sink with stall control.
// Assumes a valid/ready byte stream; keeps what it takes.
module fdc_drive_model (
    input  wire logic       clk_in, rst_n_in, stall_in, valid_in,
    input  wire logic [7:0] data_in,
    output logic            ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    logic       ph;
    // Takes a byte every other cycle unless stalled
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ph <= 1'b0;
            ready_out <= 1'b0;
        end else begin
            ph <= !ph;
            ready_out <= !stall_in && ph;
            if (valid_in && ready_out) got.push_back(data_in);
        end
    end
endmodule // fdc_drive_model

// file: sim/fdc_status_asserts.sv
// Port checker for the floppy status block.
// Assumes the top port names of fdc_status; bound below.
module fdc_status_asserts (
    // Clock, resets and host strobes
    input wire logic       CLK_SYS_IN, RST_N_IN, MASTER_RESET_N_IN,
    input wire logic       CS_N_IN, RE_N_IN, WE_N_IN,
    input wire logic [1:0] ADDR_IN,
    input wire logic [7:0] DATA_IN, DATA_OUT, DISK_BYTE_OUT,
    // Drive and handshake lines
    input wire logic       READY_IN, WRITE_PROTECT_N_IN, CMD_DONE_IN,
    input wire logic       DATA_REQUEST_FLAG_OUT, INTERRUPT_REQUEST_OUT,
    input wire logic       HEAD_LOAD_OUT, DISK_BYTE_VALID_OUT, DISK_BYTE_READY_IN
);
    logic rd_q, wr_q;
    wire  rd   = !CS_N_IN && !RE_N_IN;
    wire  wr   = !CS_N_IN && !WE_N_IN;
    wire  rd_e = rd && !rd_q;
    wire  wr_e = wr && !wr_q;
    // Strobe history for first-cycle detect
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) {rd_q, wr_q} <= 2'h0;
        else {rd_q, wr_q} <= {rd, wr};
    end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence cmd_wr; wr_e && ADDR_IN == 2'h0 && MASTER_RESET_N_IN; endsequence
    sequence go_ok; cmd_wr ##0 (READY_IN && WRITE_PROTECT_N_IN && DATA_IN[7:4] != 4'hd);
    endsequence
    chk_not_ready_bit: assert property (rd_e && ADDR_IN == 2'h0 |=>
        DATA_OUT[7] == (!$past(READY_IN) || !$past(MASTER_RESET_N_IN))) else $error("bit7 bad");
    chk_master_clr: assert property (!MASTER_RESET_N_IN |=>
        !DATA_REQUEST_FLAG_OUT && !INTERRUPT_REQUEST_OUT) else $error("master reset bad");
    chk_drq_service: assert property ((rd_e || wr_e) && ADDR_IN == 2'h3 |=>
        !DATA_REQUEST_FLAG_OUT) else $error("drq not cleared");
    chk_refuse_rw: assert property (cmd_wr ##0 (DATA_IN[7] && DATA_IN[7:4] != 4'hd
        && !READY_IN) |=> !DATA_REQUEST_FLAG_OUT ##[0:2] INTERRUPT_REQUEST_OUT)
        else $error("refusal bad");
    chk_cmd_clr_irq: assert property (go_ok |=>
        !INTERRUPT_REQUEST_OUT && HEAD_LOAD_OUT) else $error("command start bad");
    chk_track_drq: assert property (go_ok ##0 DATA_IN[7:4] == 4'hf |=>
        ##1 DATA_REQUEST_FLAG_OUT) else $error("track drq late");
    chk_drq_holds: assert property (DATA_REQUEST_FLAG_OUT && MASTER_RESET_N_IN
        && !CMD_DONE_IN && !wr_e && !(rd_e && ADDR_IN == 2'h3) |=> DATA_REQUEST_FLAG_OUT)
        else $error("drq dropped");
    chk_disk_hold: assert property (DISK_BYTE_VALID_OUT && !DISK_BYTE_READY_IN |=>
        DISK_BYTE_VALID_OUT && $stable(DISK_BYTE_OUT)) else $error("disk byte moved");
endmodule // fdc_status_asserts
bind fdc_status fdc_status_asserts fdc_status_asserts_i (.*);

// file: sim/test_fdc_status.sv
// Bench for the floppy status block.
// Assumes the drive model and checker are compiled alongside.
module test_fdc_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS_IN = 0, RST_N_IN = 0, MASTER_RESET_N_IN = 1, CS_N_IN = 1, RE_N_IN = 1;
    logic WE_N_IN = 1, READY_IN = 1, WRITE_PROTECT_N_IN = 1, TRACK_ZERO_N_IN = 1;
    logic INDEX_PULSE_N_IN = 1, HEAD_ENGAGED_IN = 1, WRITE_FAULT_N_IN = 1, stall = 0;
    logic DOUBLE_DENSITY_IN = 1;
    logic [1:0] ADDR_IN = 0;
    logic [7:0] DATA_IN = 0, READ_BYTE_IN = 0, DATA_OUT, DISK_BYTE_OUT;
    logic [5:0] ev = 0;
    wire  SEEK_ERROR_IN = ev[0], RECORD_MISSING_IN = ev[1], CRC_ERROR_IN = ev[2];
    wire  DELETED_MARK_IN = ev[3], READ_BYTE_VALID_IN = ev[4], CMD_DONE_IN = ev[5];
    wire  DATA_OE_OUT, DATA_REQUEST_FLAG_OUT, INTERRUPT_REQUEST_OUT, HEAD_LOAD_OUT;
    wire  DISK_BYTE_VALID_OUT, DISK_BYTE_READY_IN;
    int   err_total = 0, n_checks = 0, cyc_n = 0, n, k, i;
    logic [7:0] c[2] = '{8'hc0, 8'he0}, e[2] = '{8'h19, 8'h01};
    fdc_status fdc_status_i (.*);
    fdc_drive_model fdc_drive_model_i (.clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
        .stall_in(stall), .valid_in(DISK_BYTE_VALID_OUT), .data_in(DISK_BYTE_OUT),
        .ready_out(DISK_BYTE_READY_IN));
    always #20 CLK_SYS_IN = !CLK_SYS_IN;
    // Hang guard
    always @(posedge CLK_SYS_IN) if (++cyc_n == 20000) begin
        err_total++;
        end_of_test;
    end
    task cyc(input int m); repeat (m) @(posedge CLK_SYS_IN); endtask
    task chk(input logic [7:0] g, input logic [7:0] x);
        n_checks++;
        if (g !== x) begin
            err_total++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // One host access, strobe held over the taking edge
    task acc(input bit w, input logic [1:0] a, input logic [7:0] d);
        CS_N_IN <= 0; ADDR_IN <= a; DATA_IN <= d; WE_N_IN <= !w; RE_N_IN <= w;
        cyc(1);
        if (!w) chk(DATA_OE_OUT, 1);
        {CS_N_IN, WE_N_IN, RE_N_IN} <= 3'h7;
        cyc(2);
    endtask
    task rd(input logic [1:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
        acc(0, a, 0);
        chk(DATA_OUT & m, x);
    endtask
    task ev_p(input logic [5:0] v); ev <= v; cyc(1); ev <= 0; cyc(1); endtask
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Test sequence
    initial begin
        cyc(6); RST_N_IN <= 1; cyc(2);
        READY_IN <= 0; rd(0, 8'h80, 8'h80);
        READY_IN <= 1; MASTER_RESET_N_IN <= 0; rd(0, 8'h80, 8'h80);
        MASTER_RESET_N_IN <= 1; cyc(2); rd(0, 8'h00, 8'h80);
        ev_p(6'h20); $display("test ready done");
        WRITE_PROTECT_N_IN <= 0; TRACK_ZERO_N_IN <= 0; acc(1, 0, 8'h00);
        rd(0, 8'h65);
        WRITE_PROTECT_N_IN <= 1; TRACK_ZERO_N_IN <= 1; INDEX_PULSE_N_IN <= 0;
        rd(0, 8'h23);
        ev_p(6'h01); rd(0, 8'h33);
        ev_p(6'h20); rd(0, 8'h32); chk(INTERRUPT_REQUEST_OUT, 1);
        acc(1, 0, 8'h10); rd(0, 8'h23);
        ev_p(6'h20); INDEX_PULSE_N_IN <= 1; $display("test position done");
        READY_IN <= 0; acc(1, 0, 8'h80); chk(INTERRUPT_REQUEST_OUT, 1);
        rd(0, 8'h80); READY_IN <= 1; $display("test refuse done");
        acc(1, 0, 8'h88); READ_BYTE_IN <= 8'h5a; ev_p(6'h1e);
        rd(0, 8'h3b);
        rd(3, 8'h5a); chk(DATA_REQUEST_FLAG_OUT, 0);
        rd(0, 8'h39);
        ev_p(6'h10); cyc(805); rd(0, 8'h3f);
        ev_p(6'h20); $display("test read done");
        WRITE_PROTECT_N_IN <= 0;
        for (i = 0; i < 2; i++) begin
            acc(1, 0, c[i]); ev_p(6'h0e); rd(0, e[i]); ev_p(6'h20);
        end
        WRITE_PROTECT_N_IN <= 1; stall <= 1; acc(1, 0, 8'hf0); n = 0;
        for (i = 0; i < 24; i++) begin
            k = 0;
            while (DATA_REQUEST_FLAG_OUT !== 1'b1 && k < 6) begin cyc(1); k++; end
            if (k < 6) begin
                acc(1, 3, i == 0 ? 8'h4e : i == 1 ? 8'hf5 : i == 2 ? 8'hf7 : 8'h00);
                n++;
            end
        end
        chk(8'(n >= 16 && n <= 18), 1);
        stall <= 0; cyc(200);
        chk(fdc_drive_model_i.got[0], 8'h4e);
        chk(fdc_drive_model_i.got[1], 8'ha1);
        chk(8'(fdc_drive_model_i.got.size() >= n + 1), 1);
        ev_p(6'h20); $display("test track done");
        // Single density sector head: gap, ID, gap II, 128 data, gap III
        DOUBLE_DENSITY_IN <= 0; acc(1, 0, 8'hf0); n = fdc_drive_model_i.got.size();
        for (i = 0; i < 184; i++) begin
            while (DATA_REQUEST_FLAG_OUT !== 1'b1) cyc(1);
            acc(1, 3, (i < 11 || (i > 22 && i < 34) || (i > 169 && i < 180)) ? 8'hff
                : (i == 22 || i == 169) ? 8'hf7 : i == 17 ? 8'hfe : i == 40 ? 8'hfb
                : i == 20 ? 8'h01 : (i > 40 && i < 169) ? 8'(i) : 8'h00);
        end
        cyc(20);
        chk(8'(fdc_drive_model_i.got.size() == n + 186), 1);
        chk(fdc_drive_model_i.got[n + 17], 8'hfe);
        chk(fdc_drive_model_i.got[n + 41], 8'hfb);
        ev_p(6'h20); $display("test format done");
        end_of_test;
    end
endmodule // test_fdc_status
